//--- rtl/sfl_front.sv
// Serial flash command front end: lanes, write latch, command issue
`timescale 1ns/1ps
`default_nettype none
module sfl_front (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        nrst_in,
  // Flash pins
  input  wire logic        cs_n_in,
  input  wire logic        sclk_in,
  input  wire logic [3:0]  lane_in,
  output logic      [3:0]  lane_out,
  output logic      [3:0]  lane_oe_out,
  // Status
  output logic             write_latch_flag_out,
  output logic             four_lane_mode_out,
  output logic             busy_out,
  // Command issue to the array side
  output logic             cmd_valid_out,
  output logic             cmd_reject_out,
  output logic      [7:0]  cmd_opcode_out,
  output logic      [23:0] cmd_addr_out,
  output logic      [1:0]  secure_sel_out,
  input  wire logic        op_done_in,
  // Read data from the array side
  input  wire logic [7:0]  rd_data_in,
  output logic             rd_req_out,
  // Write data toward the array side
  output logic      [7:0]  wr_data_out,
  output logic             wr_valid_out,
  input  wire logic        wr_ready_in
);
  import sfl_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and clock edges
  // ----------------------------------------------------------------
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic       clk_q;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // Serial clock idles low, so no false edge follows reset
      sync1 <= 6'h2f;
      sync2 <= 6'h2f;
      clk_q <= 1'b0;
    end else begin
      sync1 <= {cs_n_in, sclk_in, lane_in};
      sync2 <= sync1;
      clk_q <= sync2[4];
    end
  end
  logic       cs_n;
  logic [3:0] lanes;
  logic       rise;
  logic       fall;
  assign cs_n  = sync2[5];
  assign lanes = sync2[3:0];
  assign rise  = sync2[4] & ~clk_q & ~cs_n;
  assign fall  = ~sync2[4] & clk_q & ~cs_n;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sfl_state_e st, next_st;
  logic [5:0]  cnt, next_cnt, ocnt, next_ocnt, plen, next_plen;
  logic [31:0] sh, next_sh;
  logic [7:0]  op, next_op, ob, next_ob;
  logic [2:0]  w, next_w;
  logic [1:0]  id_idx, next_id_idx;
  logic        latch, next_latch, qmode, next_qmode, busy, next_busy;
  logic        arm, next_arm, pend, next_pend;
  logic [7:0]  pend_byte, next_pend_byte;
  logic [3:0]  lo, next_lo, oe, next_oe;
  logic        cv, next_cv, cr, next_cr, rq, next_rq;
  logic [7:0]  cop, next_cop;
  logic [23:0] cad, next_cad;
  logic [1:0]  ssel, next_ssel;
  logic [7:0]  b0, next_b0, b1, next_b1;
  logic [1:0]  bcnt, next_bcnt;
  logic        bval, next_bval;

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  logic [31:0] sh_in;
  logic [7:0]  din_sh;
  logic [7:0]  dop;
  logic        d_addr, d_mode, d_out, d_in, d_wr, d_lone;
  logic [2:0]  d_aw, d_dw;
  logic [5:0]  d_dummy;
  always_comb begin
    case (w)
      W2:      sh_in = {sh[29:0], lanes[1:0]};
      W4:      sh_in = {sh[27:0], lanes};
      default: sh_in = {sh[30:0], lanes[0]};
    endcase
  end
  // Data byte builds in the top byte so the address survives
  always_comb begin
    case (w)
      W2:      din_sh = {sh[29:24], lanes[1:0]};
      W4:      din_sh = {sh[27:24], lanes};
      default: din_sh = {sh[30:24], lanes[0]};
    endcase
  end
  assign dop = (st == ST_CMD) ? sh_in[7:0] : op;
  always_comb begin
    d_addr = 1'b0; d_mode = 1'b0; d_out = 1'b0; d_in = 1'b0;
    d_wr = 1'b0; d_lone = 1'b0; d_aw = W1; d_dw = W1; d_dummy = 6'd0;
    case (dop)
      OP_LATCH_SET, OP_LATCH_CLEAR, OP_QMODE_ON, OP_QMODE_OFF,
      OP_RESET_ARM, OP_RESET_GO: d_lone = 1'b1;
      OP_STATUS_RD, OP_ID_RD: d_out = 1'b1;
      OP_READ, OP_SECURE_RD: begin
        d_addr = 1'b1; d_out = 1'b1;
      end
      OP_FAST_READ: begin
        d_addr = 1'b1; d_out = 1'b1; d_dummy = DUMMY_FAST;
      end
      OP_DUAL_OUT: begin
        d_addr = 1'b1; d_out = 1'b1; d_dummy = DUMMY_FAST; d_dw = W2;
      end
      OP_DUAL_IO: begin
        d_addr = 1'b1; d_mode = 1'b1; d_out = 1'b1; d_aw = W2; d_dw = W2;
      end
      OP_QUAD_OUT: begin
        d_addr = 1'b1; d_out = 1'b1; d_dummy = DUMMY_FAST; d_dw = W4;
      end
      OP_QUAD_IO: begin
        d_addr = 1'b1; d_mode = 1'b1; d_out = 1'b1; d_aw = W4; d_dw = W4;
        d_dummy = DUMMY_QUAD_IO;
      end
      OP_WORD_READ: begin
        d_addr = 1'b1; d_mode = 1'b1; d_out = 1'b1; d_aw = W4; d_dw = W4;
        d_dummy = DUMMY_WORD;
      end
      OP_PAGE_PROG, OP_SEC_PROG: begin
        d_addr = 1'b1; d_in = 1'b1; d_wr = 1'b1;
      end
      OP_QUAD_PROG: begin
        d_addr = 1'b1; d_in = 1'b1; d_wr = 1'b1; d_dw = W4;
      end
      OP_PAGE_ERASE, OP_SECT_ERASE, OP_HALF_ERASE, OP_BLOCK_ERASE,
      OP_BUF_COMMIT, OP_SEC_ERASE: begin
        d_addr = 1'b1; d_wr = 1'b1;
      end
      OP_CHIP_ERASE, OP_CHIP_ERASE2: d_wr = 1'b1;
      OP_STATUS_WR, OP_CONFIG_WR: begin
        d_in = 1'b1; d_wr = 1'b1;
      end
      default: d_lone = 1'b0;
    endcase
    if (qmode) begin
      d_aw = W4;
      d_dw = W4;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic [5:0] cnt_w;
  logic [7:0] stat_byte;
  logic       sec_ok;
  logic       bpush, bpop;
  always_comb begin
    cnt_w = cnt + {3'b000, w};
    stat_byte = 8'h00;
    stat_byte[STAT_LATCH_BIT] = latch;
    stat_byte[STAT_BUSY_BIT] = busy;
    sec_ok = (sh[23:16] == 8'h00) && (sh[11:9] == 3'b000) &&
             (sh[15:12] != 4'h0) && (sh[15:12] <= SEC_REG_MAX);
    next_st = st; next_cnt = cnt; next_ocnt = ocnt; next_plen = plen;
    next_sh = sh; next_op = op; next_ob = ob; next_w = w;
    next_id_idx = id_idx; next_latch = latch; next_qmode = qmode;
    next_busy = busy; next_arm = arm; next_pend = pend;
    next_pend_byte = pend_byte; next_lo = lo; next_oe = oe;
    next_cv = 1'b0; next_cr = 1'b0; next_rq = 1'b0;
    next_cop = cop; next_cad = cad; next_ssel = ssel;
    // Clear first, so a byte landing in the same cycle wins
    bpush = pend && (bcnt != 2'd2);
    bpop = bval && wr_ready_in;
    if (bpush) begin
      next_pend = 1'b0;
    end
    if (op_done_in && busy) begin
      next_busy = 1'b0;
      next_latch = 1'b0;
    end
    if (cs_n) begin
      next_oe = 4'h0;
      if (st == ST_WAITCS) begin
        case (op)
          OP_LATCH_SET:   next_latch = 1'b1;
          OP_LATCH_CLEAR: next_latch = 1'b0;
          OP_QMODE_ON:    next_qmode = 1'b1;
          OP_QMODE_OFF:   next_qmode = 1'b0;
          OP_RESET_GO: if (arm) begin
            next_latch = 1'b0;
            next_qmode = 1'b0;
            next_busy = 1'b0;
          end
          default: next_qmode = qmode;
        endcase
        next_arm = (op == OP_RESET_ARM);
      end else if ((st == ST_ADDR || st == ST_DIN || st == ST_DUMMY) && d_wr &&
                   (st != ST_ADDR || !d_addr)) begin
        next_cop = op;
        next_cad = sh[23:0];
        if (latch && !busy) begin
          next_cv = 1'b1;
          next_busy = 1'b1;
        end else begin
          next_cr = 1'b1;
        end
        next_arm = 1'b0;
      end else if (st != ST_IDLE) begin
        next_arm = 1'b0;
      end
      next_st = ST_IDLE;
    end else if (st == ST_IDLE) begin
      next_st = ST_CMD;
      next_cnt = 6'd0;
      next_w = qmode ? W4 : W1;
    end else if (rise) begin
      next_sh = sh_in;
      next_cnt = cnt_w;
      case (st)
        ST_CMD: if (cnt_w == CMD_BITS) begin
          next_op = sh_in[7:0];
          next_cnt = 6'd0;
          next_sh = 32'h0;
          next_id_idx = 2'd0;
          if (d_lone) begin
            next_st = ST_WAITCS;
          end else if (d_addr) begin
            next_st = ST_ADDR;
            next_w = d_aw;
            next_plen = d_mode ? ADDR_MODE_BITS : ADDR_BITS;
          end else if (d_out) begin
            next_st = ST_DOUT;
            next_w = d_dw;
            next_ocnt = 6'd0;
            next_ob = (sh_in[7:0] == OP_ID_RD) ? MFR_ID : stat_byte;
          end else if (d_in) begin
            next_st = ST_DIN;
            next_w = d_dw;
          end else begin
            next_st = d_wr ? ST_DIN : ST_IGNORE;
          end
        end
        ST_ADDR: if (cnt_w == plen) begin
          next_cnt = 6'd0;
          if (d_mode) begin
            next_sh = {8'h00, sh_in[31:8]};
          end
          next_st = (d_dummy != 6'd0) ? ST_DUMMY :
                    d_out ? ST_DOUT : ST_DIN;
          next_w = (d_dummy != 6'd0) ? w : d_dw;
          next_ocnt = 6'd0;
          next_ob = rd_data_in;
          if (d_out) begin
            next_cop = op;
            next_cad = d_mode ? sh_in[31:8] : sh_in[23:0];
            next_cv = (d_dummy == 6'd0);
            next_rq = (d_dummy == 6'd0);
          end
        end
        ST_DUMMY: begin
          next_sh = sh;
          next_cnt = cnt + 6'd1;
          if (cnt + 6'd1 == d_dummy) begin
            next_st = ST_DOUT;
            next_w = d_dw;
            next_ob = rd_data_in;
            next_cv = 1'b1;
            next_rq = 1'b1;
          end
        end
        ST_DIN: begin
          next_sh = {din_sh, sh[23:0]};
          if (cnt_w == BYTE_BITS) begin
            next_cnt = 6'd0;
            next_sh = {8'h00, sh[23:0]};
            if (latch && !busy && d_in) begin
              next_pend = 1'b1;
              next_pend_byte = din_sh;
            end
          end
        end
        default: next_sh = sh;
      endcase
      if (st == ST_DOUT) begin
        next_sh = sh;
        next_cnt = cnt;
      end
    end else if (fall && st == ST_DOUT) begin
      next_oe = (w == W4) ? 4'hf : (w == W2) ? 4'h3 : 4'h2;
      case (w)
        W2:      next_lo = {2'b00, ob[7], ob[6]};
        W4:      next_lo = ob[7:4];
        default: next_lo = {2'b00, ob[7], 1'b0};
      endcase
      next_ob = ob << w;
      next_ocnt = ocnt + {3'b000, w};
      if (ocnt + {3'b000, w} == BYTE_BITS) begin
        next_ocnt = 6'd0;
        if (op == OP_ID_RD) begin
          next_id_idx = (id_idx == ID_LAST) ? id_idx : id_idx + 2'd1;
          next_ob = (id_idx == 2'd0) ? DEV_ID_HI :
                    (id_idx == 2'd1) ? DEV_ID_LO : 8'h00;
        end else if (op == OP_STATUS_RD) begin
          next_ob = stat_byte;
        end else begin
          next_ob = rd_data_in;
          next_rq = 1'b1;
        end
      end
    end
    if (next_cv && (op == OP_SEC_PROG || op == OP_SEC_ERASE || op == OP_SECURE_RD)) begin
      next_ssel = sec_ok ? sh[13:12] : 2'b00;
    end
  end
  // Write data buffer, pop from b0, push lands behind the survivor
  always_comb begin
    next_b0 = b0; next_b1 = b1; next_bcnt = bcnt;
    case ({bpush, bpop})
      2'b10: begin
        if (bcnt == 2'd0) next_b0 = pend_byte;
        else next_b1 = pend_byte;
        next_bcnt = bcnt + 2'd1;
      end
      2'b01: begin
        next_b0 = b1;
        next_bcnt = bcnt - 2'd1;
      end
      2'b11: begin
        if (bcnt == 2'd1) next_b0 = pend_byte;
        else begin
          next_b0 = b1;
          next_b1 = pend_byte;
        end
      end
      default: next_bcnt = bcnt;
    endcase
    next_bval = (next_bcnt != 2'd0);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= ST_IDLE; cnt <= 6'd0; ocnt <= 6'd0; plen <= ADDR_BITS;
      sh <= 32'h0; op <= 8'h00; ob <= 8'h00; w <= W1; id_idx <= 2'd0;
      latch <= 1'b0; qmode <= 1'b0; busy <= 1'b0; arm <= 1'b0;
      pend <= 1'b0; pend_byte <= 8'h00; lo <= 4'h0; oe <= 4'h0;
      cv <= 1'b0; cr <= 1'b0; rq <= 1'b0; cop <= 8'h00; cad <= 24'h0;
      ssel <= 2'b00; b0 <= 8'h00; b1 <= 8'h00; bcnt <= 2'd0; bval <= 1'b0;
    end else begin
      st <= next_st; cnt <= next_cnt; ocnt <= next_ocnt; plen <= next_plen;
      sh <= next_sh; op <= next_op; ob <= next_ob; w <= next_w;
      id_idx <= next_id_idx; latch <= next_latch; qmode <= next_qmode;
      busy <= next_busy; arm <= next_arm; pend <= next_pend;
      pend_byte <= next_pend_byte; lo <= next_lo; oe <= next_oe;
      cv <= next_cv; cr <= next_cr; rq <= next_rq; cop <= next_cop;
      cad <= next_cad; ssel <= next_ssel; b0 <= next_b0; b1 <= next_b1;
      bcnt <= next_bcnt; bval <= next_bval;
    end
  end

  assign lane_out             = lo;
  assign lane_oe_out          = oe;
  assign write_latch_flag_out = latch;
  assign four_lane_mode_out   = qmode;
  assign busy_out             = busy;
  assign cmd_valid_out        = cv;
  assign cmd_reject_out       = cr;
  assign cmd_opcode_out       = cop;
  assign cmd_addr_out         = cad;
  assign secure_sel_out       = ssel;
  assign rd_req_out           = rq;
  assign wr_data_out          = b0;
  assign wr_valid_out         = bval;
endmodule
`default_nettype wire

//--- rtl/sfl_pkg.sv
// Constants, opcodes and state encoding of the flash command front end
//
// Operation
// - Two-lane output: lane1 odd bits, lane0 even
// - Two-lane address and mode, odd bits lane1
// - Four-lane data: upper nibble then lower nibble
// - Four-lane address and mode, nibble per clock
// - Fast four-lane read: four dummy clocks
// - Four-lane word read: two dummy clocks
// - Four-lane command mode: opcode in two clocks
// - Security register address fields and selection; secure read decodes sh before the last address group is shifted in
// - Identification opcode returns three ID bytes
// - Latch-set opcode sets the write latch
// - Latch-clear lone opcode clears the latch
// - Latch clears at reset and op completion
// - Latch clear rejects program, erase, status write
// - Latch readable as status bit one
package sfl_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LATCH_SET   = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_RD   = 8'h05;
  localparam logic [7:0] OP_ID_RD       = 8'h9f;
  localparam logic [7:0] OP_READ        = 8'h03;
  localparam logic [7:0] OP_FAST_READ   = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT    = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO     = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT    = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO     = 8'heb;
  localparam logic [7:0] OP_WORD_READ   = 8'he7;
  localparam logic [7:0] OP_SECURE_RD   = 8'h48;
  localparam logic [7:0] OP_PAGE_PROG   = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG   = 8'h32;
  localparam logic [7:0] OP_PAGE_ERASE  = 8'h81;
  localparam logic [7:0] OP_SECT_ERASE  = 8'h20;
  localparam logic [7:0] OP_HALF_ERASE  = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE  = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE2 = 8'hc7;
  localparam logic [7:0] OP_BUF_COMMIT  = 8'h9d;
  localparam logic [7:0] OP_STATUS_WR   = 8'h01;
  localparam logic [7:0] OP_CONFIG_WR   = 8'h31;
  localparam logic [7:0] OP_SEC_ERASE   = 8'h44;
  localparam logic [7:0] OP_SEC_PROG    = 8'h42;
  localparam logic [7:0] OP_QMODE_ON    = 8'h38;
  localparam logic [7:0] OP_QMODE_OFF   = 8'hff;
  localparam logic [7:0] OP_RESET_ARM   = 8'h66;
  localparam logic [7:0] OP_RESET_GO    = 8'h99;

  // ----------------------------------------------------------------
  // Phase lengths, lane widths, dummy clocks
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_BITS       = 6'd8;
  localparam logic [5:0] ADDR_BITS      = 6'd24;
  localparam logic [5:0] ADDR_MODE_BITS = 6'd32;
  localparam logic [5:0] BYTE_BITS      = 6'd8;
  localparam logic [2:0] W1             = 3'd1;
  localparam logic [2:0] W2             = 3'd2;
  localparam logic [2:0] W4             = 3'd4;
  localparam logic [5:0] DUMMY_FAST     = 6'd8;
  localparam logic [5:0] DUMMY_QUAD_IO  = 6'd4;
  localparam logic [5:0] DUMMY_WORD     = 6'd2;
  localparam logic [1:0] ID_LAST        = 2'd2;

  // ----------------------------------------------------------------
  // Status byte and security register fields
  // ----------------------------------------------------------------
  localparam int         STAT_BUSY_BIT  = 0;
  localparam int         STAT_LATCH_BIT = 1;
  localparam logic [3:0] SEC_REG_MAX    = 4'h3;
  // Arbitrary identification values
  localparam logic [7:0] MFR_ID         = 8'h5a;
  localparam logic [7:0] DEV_ID_HI      = 8'h40;
  localparam logic [7:0] DEV_ID_LO      = 8'h13;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CMD    = 3'b001,
    ST_ADDR   = 3'b010,
    ST_DUMMY  = 3'b011,
    ST_DIN    = 3'b100,
    ST_DOUT   = 3'b101,
    ST_WAITCS = 3'b110,
    ST_IGNORE = 3'b111
  } sfl_state_e;

endpackage

//--- verification/sfl_front_chk.sv
// Port assertions for the flash command front end
`timescale 1ns/1ps
`default_nettype none
module sfl_front_chk (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        nrst_in,
  // Watched ports
  input  wire logic        cs_n_in,
  input  wire logic [3:0]  lane_oe_out,
  input  wire logic        write_latch_flag_out,
  input  wire logic        four_lane_mode_out,
  input  wire logic        busy_out,
  input  wire logic        cmd_valid_out,
  input  wire logic        cmd_reject_out,
  input  wire logic [7:0]  cmd_opcode_out,
  input  wire logic [23:0] cmd_addr_out,
  input  wire logic [1:0]  secure_sel_out,
  input  wire logic        op_done_in,
  input  wire logic [7:0]  wr_data_out,
  input  wire logic        wr_valid_out,
  input  wire logic        wr_ready_in
);
  import sfl_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  logic sec_ok;
  assign sec_ok = cmd_opcode_out == OP_SEC_PROG && cmd_addr_out[23:16] == 8'h00
                  && cmd_addr_out[11:9] == 3'h0 && cmd_addr_out[15:12] inside {4'h1, 4'h2, 4'h3};
  // Synchroniser and output register take three clocks, which the four-sample window just covers
  a_oe_idle: assert property (cs_n_in [*4] |-> lane_oe_out == 4'h0)
    else $error("lanes driven while deselected");
  a_reject_cause: assert property (cmd_reject_out |-> !write_latch_flag_out || busy_out)
    else $error("reject with latch set and idle");
  a_accept_latch: assert property ($rose(busy_out) |-> cmd_valid_out && write_latch_flag_out)
    else $error("busy without accepted command");
  a_done_clears: assert property (op_done_in && busy_out |=> !busy_out && !write_latch_flag_out)
    else $error("completion left latch or busy");
  a_set_at_close: assert property ($rose(write_latch_flag_out) |-> $past(cs_n_in) && $past(cs_n_in, 2))
    else $error("latch set inside frame");
  a_clear_cause: assert property ($fell(write_latch_flag_out)
    |-> $past(op_done_in) || ($past(cs_n_in) && $past(cs_n_in, 2)))
    else $error("latch cleared without cause");
  a_mode_close: assert property ($changed(four_lane_mode_out) |-> $past(cs_n_in) && $past(cs_n_in, 2))
    else $error("lane mode changed inside frame");
  a_busy_hold: assert property (busy_out && !op_done_in && !cs_n_in |=> busy_out)
    else $error("busy dropped early");
  a_secure_sel: assert property (cmd_valid_out && sec_ok |-> secure_sel_out == cmd_addr_out[13:12])
    else $error("wrong security register");
  a_buf_hold: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_data_out))
    else $error("buffer head lost in stall");
  c_accept: cover property (cmd_valid_out && busy_out);
  c_reject: cover property (cmd_reject_out);
  c_quad: cover property (four_lane_mode_out && write_latch_flag_out);
endmodule
bind sfl_front sfl_front_chk sfl_front_chk_inst (.*);
`default_nettype wire

//--- verification/sfl_host_model.sv
// Host controller model: chip select, serial clock and lanes
`timescale 1ns/1ps
`default_nettype none
module sfl_host_model (
  // Flash pins
  output logic            cs_n,
  output logic            sclk,
  output var logic [3:0]  lane,
  input  wire logic [3:0] dev_lane,
  input  wire logic [3:0] dev_oe
);
  logic [3:0] hv;
  logic [3:0] he;
  // Released lanes show the inverse of the last value, never a stale copy
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      lane[k] = dev_oe[k] ? dev_lane[k] : (he[k] ? hv[k] : ~hv[k]);
    end
  end
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    hv = 4'h0;
    he = 4'h0;
  end
  // Clock stands low outside frames; odd offset keeps it unrelated in phase
  task automatic open_f();
    #13;
    cs_n = 1'b0;
    #200;
  endtask
  task automatic close_f();
    he = 4'h0;
    #200;
    cs_n = 1'b1;
    #1600;
  endtask
  // Lane k carries bit k of each group, groups MSB first
  task automatic send(input int w, input int n, input logic [31:0] v);
    for (int i = n - w; i >= 0; i -= w) begin
      he = (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hf;
      hv = 4'(v >> i) & he;
      #200;
      sclk = 1'b1;
      #200;
      sclk = 1'b0;
    end
  endtask
  // Sampled just before the fall, where the device output is settled
  task automatic recv(input int w, input int n, output logic [31:0] v);
    v = '0;
    he = 4'h0;
    for (int i = n - w; i >= 0; i -= w) begin
      #200;
      sclk = 1'b1;
      #200;
      v = (v << w) | ((w == 1) ? 32'(lane[1]) : 32'(lane & ((w == 2) ? 4'h3 : 4'hf)));
      sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- verification/test_serial_flash_write_latch_and_lanes.sv
// Self-checking bench for the flash command front end
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_write_latch_and_lanes;
  import sfl_pkg::*;
  logic        clk, nrst, cs_n, sclk, latch, mode, busy, cvalid, creject;
  logic        op_done, rd_req, wr_valid, wr_ready;
  logic [3:0]  lane, lane_o, lane_oe;
  logic [7:0]  copc, rd_data, wr_data;
  logic [23:0] caddr;
  logic [1:0]  ssel;
  logic [7:0]  q[$];
  int          n_fail = 0, compares = 0, cyc = 0, n_valid = 0, n_rej = 0, rd_idx = 0;
  assign rd_data = 8'h3c + 8'(rd_idx * 17);
  sfl_front sfl_front_inst (.sys_clk_in(clk), .nrst_in(nrst), .cs_n_in(cs_n), .sclk_in(sclk),
    .lane_in(lane), .lane_out(lane_o), .lane_oe_out(lane_oe), .write_latch_flag_out(latch),
    .four_lane_mode_out(mode), .busy_out(busy), .cmd_valid_out(cvalid),
    .cmd_reject_out(creject), .cmd_opcode_out(copc), .cmd_addr_out(caddr),
    .secure_sel_out(ssel), .op_done_in(op_done), .rd_data_in(rd_data), .rd_req_out(rd_req),
    .wr_data_out(wr_data), .wr_valid_out(wr_valid), .wr_ready_in(wr_ready));
  sfl_host_model sfl_host_model_inst (.cs_n(cs_n), .sclk(sclk), .lane(lane),
    .dev_lane(lane_o), .dev_oe(lane_oe));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cvalid === 1'b1) n_valid <= n_valid + 1;
    if (creject === 1'b1) n_rej <= n_rej + 1;
    if (rd_req === 1'b1) rd_idx <= rd_idx + 1;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) q.push_back(wr_data);
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tx(input int w, input int n, input logic [31:0] v);
    sfl_host_model_inst.send(w, n, v);
  endtask
  task automatic op(input int w, input logic [7:0] c);
    sfl_host_model_inst.open_f();
    tx(w, 8, c);
    sfl_host_model_inst.close_f();
  endtask
  task automatic done();
    @(negedge clk) op_done = 1'b1;
    @(negedge clk) op_done = 1'b0;
    @(negedge clk);
  endtask
  // Read: opcode, address lanes, dummy clocks, two bytes on dw lanes
  task automatic t_rd(input logic [7:0] c, input int aw, input int an,
                      input logic [31:0] ad, input int dm, input int dw);
    logic [31:0] v;
    logic [7:0]  e;
    int          nv;
    e = rd_data;
    nv = n_valid;
    sfl_host_model_inst.open_f();
    tx(1, 8, c);
    tx(aw, an, ad);
    sfl_host_model_inst.recv(1, dm, v);
    sfl_host_model_inst.recv(dw, 16, v);
    sfl_host_model_inst.close_f();
    cmp("read data", {16'h0, e, 8'(e + 8'h11)}, v);
    cmp("read addr", (an == 32) ? ad[31:8] : ad[23:0], 32'(caddr));
    cmp("read start", nv + 1, n_valid);
  endtask
  task automatic t_id();
    logic [31:0] v;
    int          nv;
    nv = n_valid;
    sfl_host_model_inst.open_f();
    tx(1, 8, OP_ID_RD);
    sfl_host_model_inst.recv(1, 24, v);
    sfl_host_model_inst.close_f();
    cmp("id bytes", {8'h00, MFR_ID, DEV_ID_HI, DEV_ID_LO}, v);
    cmp("id no start", nv, n_valid);
  endtask
  task automatic t_latch();
    logic [31:0] v;
    op(1, OP_LATCH_SET);
    cmp("latch set", 1, latch);
    sfl_host_model_inst.open_f();
    tx(1, 8, OP_STATUS_RD);
    sfl_host_model_inst.recv(1, 8, v);
    sfl_host_model_inst.close_f();
    cmp("status", 32'h02, v);
    op(1, OP_LATCH_CLEAR);
    cmp("latch clear", 0, latch);
  endtask
  task automatic t_program(input logic [7:0] c);
    int nv;
    nv = n_valid;
    sfl_host_model_inst.open_f();
    tx(1, 8, c);
    tx(1, 24, 24'h012345);
    tx(1, 16, 16'h3cc3);
    sfl_host_model_inst.close_f();
  endtask
  task automatic t_write();
    op(1, OP_PAGE_PROG);
    t_program(OP_PAGE_PROG);
    cmp("refused", {8'(n_rej), 8'(n_valid), 7'h00, busy, 8'(q.size())}, 32'h01000000);
    op(1, OP_LATCH_SET);
    t_program(OP_PAGE_PROG);
    cmp("stalled", {wr_valid, busy, latch, copc}, {3'b111, OP_PAGE_PROG});
    cmp("prog addr", caddr, 24'h012345);
    @(negedge clk) wr_ready = 1'b1;
    repeat (4) @(negedge clk);
    wr_ready = 1'b0;
    cmp("drained", {8'(q.size()), q[0], q[1]}, {8'd2, 16'h3cc3});
    done();
    cmp("completed", {busy, latch}, 2'b00);
    q.delete();
  endtask
  task automatic t_quad();
    op(1, OP_QMODE_ON);
    cmp("mode on", 1, mode);
    op(4, OP_LATCH_SET);
    cmp("quad latch", 1, latch);
    @(negedge clk) wr_ready = 1'b1;
    sfl_host_model_inst.open_f();
    tx(4, 8, OP_SEC_PROG);
    tx(4, 24, 24'h002010);
    tx(4, 8, 8'h96);
    sfl_host_model_inst.close_f();
    cmp("secure sel", 2, ssel);
    cmp("quad byte", 8'h96, q[0]);
    done();
    wr_ready = 1'b0;
    q.delete();
    op(4, OP_QMODE_OFF);
    cmp("mode off", 0, mode);
  endtask
  initial begin
    nrst = 1'b0;
    op_done = 1'b0;
    wr_ready = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    cmp("reset", {latch, mode, busy, lane_oe}, 7'h00);
    t_latch();
    t_write();
    t_id();
    t_rd(OP_DUAL_OUT, 1, 24, 24'h000200, 8, 2);
    t_rd(OP_DUAL_IO, 2, 32, 32'h12345600, 0, 2);
    t_rd(OP_QUAD_IO, 4, 32, 32'h65432100, 4, 4);
    t_rd(OP_WORD_READ, 4, 32, 32'h000a1000, 2, 4);
    t_quad();
    op(1, OP_LATCH_SET);
    op(1, OP_RESET_ARM);
    op(1, OP_RESET_GO);
    cmp("soft reset", 0, latch);
    close_out();
  end
endmodule
`default_nettype wire
